/* scdp_chan_pos.sv */
/*
 * One channel's data position register.
 * Assumes load is a one-cycle pulse already checked by the parent.
 */
`timescale 1ns/1ps
module scdp_chan_pos import scdp_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic load,
	input wire scdp_pos_t sel,
	output scdp_pos_t pos
);

	typedef struct packed {
		scdp_pos_t pos;
	} scdp_cp_t;

	scdp_cp_t s_reg;
	scdp_cp_t s_next;

	always_comb begin
		s_next = s_reg;
		if (load) begin
			s_next.pos = sel;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg.pos <= POS_RISE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pos = s_reg.pos;

endmodule

/* scdp_pkg.sv */
/*
 * Shared constants and types for the sample clock and data position block.
 * Assumes one 40 MHz clock domain and software-driven configuration pulses.
 */
package scdp_pkg;

	// sample clock sources
	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'h0,
		SRC_STROBE = 2'h1,
		SRC_FRONT = 2'h2,
		SRC_STAR = 2'h3
	} scdp_src_t;

	// phase-lock reference sources
	typedef enum logic [1:0] {
		REF_NONE = 2'h0,
		REF_FRONT = 2'h1,
		REF_BACKPLANE = 2'h2,
		REF_CARD_TRIG7 = 2'h3
	} scdp_ref_t;

	// data position per channel
	typedef enum logic [1:0] {
		POS_RISE = 2'h0,
		POS_FALL = 2'h1,
		POS_DELAY = 2'h2,
		POS_BAD = 2'h3
	} scdp_pos_t;

	typedef enum logic [2:0] {
		ERR_OK = 3'h0,
		ERR_BUSY = 3'h1,
		ERR_STROBE_GEN = 3'h2,
		ERR_NO_STAR = 3'h3,
		ERR_PARTIAL = 3'h4,
		ERR_NO_REF = 3'h5,
		ERR_UNCOMMIT = 3'h6,
		ERR_RANGE = 3'h7
	} scdp_err_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOCKING = 2'h1,
		ST_READY = 2'h2
	} scdp_state_t;

	localparam int RATE_W = 32;
	localparam int DELAY_W = 8;
	localparam int PHASE_W = 9;
	localparam logic [RATE_W-1:0] RST_RATE_KHZ = 32'h0000_1388;
	localparam logic [RATE_W-1:0] BACKPLANE_REF_KHZ = 32'h0000_2710;
	localparam logic [RATE_W-1:0] RST_REF_KHZ = 32'h0000_0000;
	localparam logic [DELAY_W-1:0] RST_DELAY = 8'h00;
	localparam logic [PHASE_W-1:0] RST_PHASE = 9'h000;
	// phase value that stands for one whole sample clock period
	localparam logic [PHASE_W-1:0] PHASE_FULL = 9'h100;

endpackage

/* scdp_pll_model.sv */
/*
 * Behavioural PLL and reference model on the far side of scdp_top.
 * Assumes the bench sets the lock time and can force a loss of lock.
 */
`timescale 1ns/1ps
module scdp_pll_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pll_enable,
	input wire logic [7:0] lock_cyc,
	input wire logic drop,
	output logic pll_locked
);
	int cnt;

	// lock only while enabled and drop is low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			pll_locked <= 1'b0;
		end else begin
			cnt <= !pll_enable ? 0 : (cnt < lock_cyc) ? cnt + 1 : cnt;
			pll_locked <= pll_enable && cnt >= lock_cyc && !drop;
		end
	end
endmodule

/* scdp_top.sv */
/*
 * Sample clock source, phase-lock reference, data position and sample
 * clock phase trim control, all through plain configuration ports.
 * Assumes request pulses last one cycle and pll_locked is synchronous.
 */
`timescale 1ns/1ps
module scdp_top import scdp_pkg::*; #(
	parameter int NCH = 32,
	parameter logic [RATE_W-1:0] RATE_STEP_KHZ = 32'h0000_03E8,
	parameter logic [RATE_W-1:0] RATE_MIN_KHZ = 32'h0000_03E8,
	parameter logic [RATE_W-1:0] RATE_MAX_KHZ = 32'h0001_86A0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic busy,
	input wire logic acq_mode,
	input wire logic star_slot,
	input wire logic delay_all_family,
	input wire logic pll_locked,
	input wire logic cfg_valid,
	input wire scdp_src_t cfg_src,
	input wire scdp_ref_t cfg_ref,
	input wire logic [RATE_W-1:0] cfg_rate_khz,
	input wire logic [RATE_W-1:0] cfg_ref_rate_khz,
	input wire logic commit,
	input wire logic pos_valid,
	input wire logic [NCH-1:0] pos_mask,
	input wire scdp_pos_t pos_sel,
	input wire logic [DELAY_W-1:0] pos_delay,
	input wire logic adj_valid,
	input wire logic [PHASE_W-1:0] adj_val,
	output scdp_src_t src_applied,
	output scdp_ref_t ref_applied,
	output logic [RATE_W-1:0] rate_applied_khz,
	output logic [RATE_W-1:0] ref_rate_khz,
	output logic [DELAY_W-1:0] delay_frac,
	output logic [PHASE_W-1:0] phase_delay,
	output logic pll_enable,
	output logic hold_data,
	output logic committed,
	output logic delay_jitter,
	output scdp_err_t err_code,
	output logic err_pulse,
	output scdp_pos_t [NCH-1:0] chan_pos
);

	typedef struct packed {
		scdp_state_t state;
		scdp_src_t src;
		scdp_ref_t refc;
		logic [RATE_W-1:0] rate;
		logic [RATE_W-1:0] ref_rate;
		logic [DELAY_W-1:0] delay;
		logic [PHASE_W-1:0] phase;
		logic pll_en;
		logic hold;
		logic committed;
		scdp_err_t err;
		logic err_pulse;
		logic pos_load;
		logic [NCH-1:0] pos_mask;
		scdp_pos_t pos_sel;
		logic jitter;
	} scdp_st_t;

	scdp_st_t s_reg;
	scdp_st_t s_next;
	logic cfg_ok;
	logic pos_ok;
	logic adj_ok;
	logic need_pll;
	logic [RATE_W:0] rate_round;
	logic [RATE_W-1:0] rate_coerced;
	logic [NCH-1:0] delay_chans;

	// nearest supported rate: round to the step grid, then clamp
	always_comb begin
		rate_round = ({1'b0, cfg_rate_khz} + {2'b00, RATE_STEP_KHZ[RATE_W-1:1]});
		rate_round = (rate_round / {1'b0, RATE_STEP_KHZ}) * {1'b0, RATE_STEP_KHZ};
		if (rate_round < {1'b0, RATE_MIN_KHZ}) begin
			rate_coerced = RATE_MIN_KHZ;
		end else if (rate_round > {1'b0, RATE_MAX_KHZ}) begin
			rate_coerced = RATE_MAX_KHZ;
		end else begin
			rate_coerced = rate_round[RATE_W-1:0];
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.err_pulse = 1'b0;
		s_next.pos_load = 1'b0;
		cfg_ok = 1'b0;
		pos_ok = 1'b0;
		adj_ok = 1'b0;

		if (cfg_valid) begin
			s_next.err_pulse = 1'b1;
			if (busy) begin
				s_next.err = ERR_BUSY;
			end else if (cfg_src == SRC_STROBE && !acq_mode) begin
				s_next.err = ERR_STROBE_GEN;
			end else if (cfg_src == SRC_STAR && !star_slot) begin
				s_next.err = ERR_NO_STAR;
			end else begin
				cfg_ok = 1'b1;
				s_next.err = ERR_OK;
				s_next.src = cfg_src;
				s_next.refc = cfg_ref;
				// external clocks keep the stated rate for bookkeeping only
				s_next.rate = (cfg_src == SRC_INTERNAL) ? rate_coerced : cfg_rate_khz;
				s_next.ref_rate = (cfg_ref == REF_BACKPLANE) ? BACKPLANE_REF_KHZ :
					(cfg_ref == REF_NONE) ? RST_REF_KHZ : cfg_ref_rate_khz;
				// a new clock plan voids the old commit and trim
				s_next.committed = 1'b0;
				s_next.phase = RST_PHASE;
			end
		end else if (commit) begin
			s_next.committed = 1'b1;
		end

		if (pos_valid && !cfg_valid) begin
			s_next.err_pulse = 1'b1;
			if (pos_sel == POS_BAD) begin
				s_next.err = ERR_RANGE;
			end else if (pos_sel == POS_DELAY && delay_all_family && !(&pos_mask)) begin
				s_next.err = ERR_PARTIAL;
			end else begin
				pos_ok = 1'b1;
				s_next.err = ERR_OK;
				s_next.pos_load = 1'b1;
				s_next.pos_mask = pos_mask;
				s_next.pos_sel = pos_sel;
				if (pos_sel == POS_DELAY) begin
					s_next.delay = pos_delay;
				end
			end
		end

		if (adj_valid && !cfg_valid && !pos_valid) begin
			s_next.err_pulse = 1'b1;
			if (s_reg.refc == REF_NONE) begin
				s_next.err = ERR_NO_REF;
			end else if (!s_reg.committed) begin
				s_next.err = ERR_UNCOMMIT;
			end else if (adj_val > PHASE_FULL) begin
				s_next.err = ERR_RANGE;
			end else begin
				adj_ok = 1'b1;
				s_next.err = ERR_OK;
				s_next.phase = adj_val;
			end
		end

		need_pll = (s_next.src == SRC_INTERNAL) && (s_next.refc != REF_NONE);
		s_next.pll_en = need_pll;

		case (s_reg.state)
			ST_IDLE: begin
				s_next.state = need_pll ? ST_LOCKING : ST_READY;
			end
			ST_LOCKING: begin
				if (!need_pll || (pll_locked && !cfg_ok)) begin
					s_next.state = ST_READY;
				end
			end
			ST_READY: begin
				// a fresh plan that needs the PLL or a lost lock sends the data path back on hold
				if (need_pll && (cfg_ok || !pll_locked)) begin
					s_next.state = ST_LOCKING;
				end
			end
			default: begin
				s_next.state = ST_IDLE;
			end
		endcase
		s_next.hold = (s_next.state != ST_READY);
		// flags any channel on the delayed position, which sees more jitter
		s_next.jitter = |delay_chans;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg.state <= ST_IDLE;
			s_reg.src <= SRC_INTERNAL;
			s_reg.refc <= REF_NONE;
			s_reg.rate <= RST_RATE_KHZ;
			s_reg.ref_rate <= RST_REF_KHZ;
			s_reg.delay <= RST_DELAY;
			s_reg.phase <= RST_PHASE;
			s_reg.pll_en <= 1'b0;
			s_reg.hold <= 1'b1;
			s_reg.committed <= 1'b0;
			s_reg.err <= ERR_OK;
			s_reg.err_pulse <= 1'b0;
			s_reg.pos_load <= 1'b0;
			s_reg.pos_mask <= '0;
			s_reg.pos_sel <= POS_RISE;
			s_reg.jitter <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		scdp_chan_pos u_pos (
			.clk(clk),
			.arst_n(arst_n),
			.load(s_reg.pos_load && s_reg.pos_mask[i]),
			.sel(s_reg.pos_sel),
			.pos(chan_pos[i])
		);
		assign delay_chans[i] = (chan_pos[i] == POS_DELAY);
	end

	assign src_applied = s_reg.src;
	assign ref_applied = s_reg.refc;
	assign rate_applied_khz = s_reg.rate;
	assign ref_rate_khz = s_reg.ref_rate;
	assign delay_frac = s_reg.delay;
	assign phase_delay = s_reg.phase;
	assign pll_enable = s_reg.pll_en;
	assign hold_data = s_reg.hold;
	assign committed = s_reg.committed;
	assign err_code = s_reg.err;
	assign err_pulse = s_reg.err_pulse;
	// registered so the flag leaves the block from a flop, one cycle after chan_pos
	assign delay_jitter = s_reg.jitter;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_refused(scdp_err_t e);
		err_pulse && err_code == e && $stable(src_applied);
	endsequence

	sequence s_locking;
		pll_enable && hold_data;
	endsequence

	property p_strobe_gen;
		cfg_valid && !busy && cfg_src == SRC_STROBE && !acq_mode |=> s_refused(ERR_STROBE_GEN);
	endproperty
	a_strobe_gen: assert property (p_strobe_gen) else $error("strobe source taken in generation");

	property p_no_star;
		cfg_valid && !busy && cfg_src == SRC_STAR && !star_slot |=> s_refused(ERR_NO_STAR);
	endproperty
	a_no_star: assert property (p_no_star) else $error("star source taken without star slot");

	property p_busy;
		cfg_valid && busy |=> s_refused(ERR_BUSY) && $stable(ref_applied);
	endproperty
	a_busy: assert property (p_busy) else $error("clock plan changed while busy");

	property p_rate;
		cfg_ok && cfg_src == SRC_INTERNAL |=> (rate_applied_khz % RATE_STEP_KHZ == 0) &&
			rate_applied_khz >= RATE_MIN_KHZ && rate_applied_khz <= RATE_MAX_KHZ;
	endproperty
	a_rate: assert property (p_rate) else $error("internal rate not coerced");

	property p_lock_start;
		cfg_ok && cfg_src == SRC_INTERNAL && cfg_ref != REF_NONE |=> s_locking;
	endproperty
	a_lock_start: assert property (p_lock_start) else $error("no lock wait after plan");

	property p_lock_release;
		hold_data && pll_enable && pll_locked && !cfg_valid |=> !hold_data;
	endproperty
	a_lock_release: assert property (p_lock_release) else $error("hold not released at lock");

	property p_delay_common;
		pos_ok && pos_sel == POS_DELAY |=> delay_frac == $past(pos_delay) ##1
			chan_pos[0] == ($past(pos_mask[0], 2) ? POS_DELAY : $past(chan_pos[0]));
	endproperty
	a_delay_common: assert property (p_delay_common) else $error("delay not applied");

	property p_partial;
		pos_valid && !cfg_valid && pos_sel == POS_DELAY && delay_all_family && !(&pos_mask)
			|=> err_code == ERR_PARTIAL ##1 $stable(chan_pos);
	endproperty
	a_partial: assert property (p_partial) else $error("partial delay accepted");

	property p_no_ref;
		adj_valid && !cfg_valid && !pos_valid && ref_applied == REF_NONE
			|=> err_code == ERR_NO_REF && $stable(phase_delay);
	endproperty
	a_no_ref: assert property (p_no_ref) else $error("trim accepted without reference");

	property p_trim;
		adj_ok |=> phase_delay == $past(adj_val) && committed && phase_delay <= PHASE_FULL;
	endproperty
	a_trim: assert property (p_trim) else $error("trim not immediate");

endmodule

/* scdp_top_bench.sv */
/*
 * Self-checking bench for scdp_top against an integer reference model.
 * Assumes scdp_pkg and scdp_pll_model are compiled first.
 */
`timescale 1ns/1ps
module scdp_top_bench import scdp_pkg::*;;
	localparam int NCH = 8;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic busy, acq_mode, star_slot, delay_all_family, cfg_valid, commit, pos_valid, adj_valid;
	logic drop, pll_locked, pll_enable, hold_data, committed, delay_jitter, err_pulse;
	scdp_src_t cfg_src, src_applied;
	scdp_ref_t cfg_ref, ref_applied;
	logic [RATE_W-1:0] cfg_rate_khz, cfg_ref_rate_khz, rate_applied_khz, ref_rate_khz;
	logic [NCH-1:0] pos_mask;
	scdp_pos_t pos_sel;
	logic [DELAY_W-1:0] pos_delay, delay_frac;
	logic [PHASE_W-1:0] adj_val, phase_delay;
	logic [7:0] lock_cyc;
	scdp_err_t err_code;
	scdp_pos_t [NCH-1:0] chan_pos;
	int n_errors = 0, n_checks = 0;
	int m_src = 0, m_ref = 0, m_rate = 5000, m_rr = 0, m_dly = 0, m_ph = 0, m_com = 0, m_err = 0;
	int m_pos[NCH];
	int rt_list[6] = '{0, 1499, 1500, 99499, 99500, 250000};

	always #12.5 clk = ~clk;

	scdp_top #(.NCH(NCH)) uut (.clk, .arst_n, .busy, .acq_mode, .star_slot, .delay_all_family,
		.pll_locked, .cfg_valid, .cfg_src, .cfg_ref, .cfg_rate_khz, .cfg_ref_rate_khz, .commit,
		.pos_valid, .pos_mask, .pos_sel, .pos_delay, .adj_valid, .adj_val, .src_applied,
		.ref_applied, .rate_applied_khz, .ref_rate_khz, .delay_frac, .phase_delay, .pll_enable,
		.hold_data, .committed, .delay_jitter, .err_code, .err_pulse, .chan_pos);
	scdp_pll_model pll (.clk, .arst_n, .pll_enable, .lock_cyc, .drop, .pll_locked);

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// grid of the default parameters: 1000 kHz steps, half up, then clamped
	function automatic int coerce(input int r);
		int q;
		q = (r + 500) / 1000 * 1000;
		return q < 1000 ? 1000 : q > 100000 ? 100000 : q;
	endfunction

	task automatic look(input int p);
		chk("err_pulse", err_pulse, p);
		chk("err_code", err_code, m_err);
		chk("src_applied", src_applied, m_src);
		chk("ref_applied", ref_applied, m_ref);
		chk("rate_applied_khz", rate_applied_khz, m_rate);
		chk("ref_rate_khz", ref_rate_khz, m_rr);
		chk("delay_frac", delay_frac, m_dly);
		chk("phase_delay", phase_delay, m_ph);
		chk("committed", committed, m_com);
		chk("pll_enable", pll_enable, m_src == 0 && m_ref != 0);
	endtask

	// the request is sampled at the next edge, answered in the cycle after it
	task automatic tail();
		@(posedge clk);
		cfg_valid <= 1'b0;
		pos_valid <= 1'b0;
		adj_valid <= 1'b0;
		commit <= 1'b0;
		@(negedge clk);
	endtask

	task automatic cfg(input int s, input int r, input int rt, input int rr);
		@(posedge clk);
		cfg_src <= scdp_src_t'(s);
		cfg_ref <= scdp_ref_t'(r);
		cfg_rate_khz <= rt;
		cfg_ref_rate_khz <= rr;
		cfg_valid <= 1'b1;
		tail();
		m_err = busy ? 1 : (s == 1 && !acq_mode) ? 2 : (s == 3 && !star_slot) ? 3 : 0;
		if (m_err == 0) begin
			m_src = s;
			m_ref = r;
			m_rate = s == 0 ? coerce(rt) : rt;
			m_rr = r == 0 ? 0 : r == 2 ? 10000 : rr;
			m_com = 0;
			m_ph = 0;
		end
		look(1);
	endtask

	task automatic pos(input logic [NCH-1:0] mk, input int sl, input int dl);
		@(posedge clk);
		pos_mask <= mk;
		pos_sel <= scdp_pos_t'(sl);
		pos_delay <= dl[DELAY_W-1:0];
		pos_valid <= 1'b1;
		tail();
		m_err = sl == 3 ? 7 : (sl == 2 && delay_all_family && mk != '1) ? 4 : 0;
		if (m_err == 0) begin
			for (int i = 0; i < NCH; i++) if (mk[i]) m_pos[i] = sl;
			if (sl == 2) m_dly = dl;
		end
		look(1);
		@(negedge clk);
		for (int i = 0; i < NCH; i++) chk("chan_pos", chan_pos[i], m_pos[i]);
		@(negedge clk);
		chk("delay_jitter", delay_jitter, 2 inside {m_pos});
	endtask

	task automatic adj(input int v);
		@(posedge clk);
		adj_val <= v[PHASE_W-1:0];
		adj_valid <= 1'b1;
		tail();
		m_err = m_ref == 0 ? 5 : !m_com ? 6 : v > 256 ? 7 : 0;
		if (m_err == 0) m_ph = v;
		look(1);
	endtask

	task automatic cmt();
		@(posedge clk);
		commit <= 1'b1;
		tail();
		m_com = 1;
		chk("committed", committed, 1);
	endtask

	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		conclude();
	end

	initial begin
		{busy, star_slot, delay_all_family, cfg_valid, commit, pos_valid, adj_valid, drop} = '0;
		{cfg_rate_khz, cfg_ref_rate_khz, pos_mask, pos_delay, adj_val} = '0;
		acq_mode = 1'b1;
		lock_cyc = 8'h01;
		cfg_src = SRC_INTERNAL;
		cfg_ref = REF_NONE;
		pos_sel = POS_RISE;
		void'($urandom(32'hB829));
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		star_slot <= 1'b1;
		repeat (2) @(negedge clk);
		look(0);
		chk("hold_data", hold_data, 0);
		for (int i = 0; i < NCH; i++) chk("chan_pos", chan_pos[i], 0);
		for (int s = 0; s < 4; s++)
			for (int r = 0; r < 4; r++)
				cfg(s, r, $urandom_range(200000), $urandom_range(50000));
		acq_mode <= 1'b0;
		cfg(1, 0, 3000, 0);
		star_slot <= 1'b0;
		cfg(3, 0, 3000, 0);
		busy <= 1'b1;
		cfg(2, 1, 3000, 7000);
		pos(8'h3C, 1, 0);
		busy <= 1'b0;
		foreach (rt_list[i]) cfg(0, 0, rt_list[i], 0);
		// slow lock so the held window is visible
		lock_cyc <= 8'h0C;
		cfg(0, 1, 20000, 10000);
		chk("hold_data", hold_data, 1);
		for (int i = 0; i < 40 && hold_data !== 1'b0; i++) @(negedge clk);
		chk("hold_data", hold_data, 0);
		chk("pll_locked", pll_locked, 1);
		@(posedge clk);
		drop <= 1'b1;
		repeat (3) @(negedge clk);
		chk("hold_data", hold_data, 1);
		@(posedge clk);
		drop <= 1'b0;
		cfg(0, 2, 8000, 0);
		adj(16);
		cmt();
		adj(0);
		adj(256);
		adj(257);
		adj($urandom_range(256));
		cfg(0, 0, 8000, 0);
		cmt();
		adj(5);
		pos(NCH'($urandom), 0, 0);
		pos(NCH'($urandom), 2, $urandom_range(255));
		pos(8'h0F, 2, 8'h40);
		pos(8'hFE, 2, 8'h21);
		delay_all_family <= 1'b1;
		pos(8'hF0, 2, 8'h80);
		pos('1, 2, 8'hC3);
		pos('1, 3, 0);
		pos('1, 1, 0);
		conclude();
	end
endmodule
